// ==== bps_pkg.sv ====
package bps_pkg;
  // Three-state limit-select pin encodings.
  localparam logic [1:0] LIM_LOW = 2'h0;
  localparam logic [1:0] LIM_FLOAT = 2'h1;
  localparam logic [1:0] LIM_HIGH = 2'h2;
  // Short-circuit threshold select codes for the analog comparator.
  localparam logic [1:0] SC_TH_105MV = 2'h0;
  localparam logic [1:0] SC_TH_210MV = 2'h1;
  localparam logic [1:0] SC_TH_320MV = 2'h2;
  // Soft-start figures.
  localparam int SS_STEPS = 64;
  localparam int SS_CYCLES_STD = 1024;
  localparam int SS_CYCLES_FAST = 4096;
  localparam logic [5:0] SS_CODE_MIN = 6'h00;
  localparam logic [5:0] SS_CODE_MAX = 6'h3f;
  localparam logic [11:0] SS_DIV_STD = 12'(SS_CYCLES_STD / SS_STEPS);
  localparam logic [11:0] SS_DIV_FAST = 12'(SS_CYCLES_FAST / SS_STEPS);
  // Sequencer states.
  typedef enum logic [1:0] {
    BPS_OFF = 2'b00,
    BPS_SOFT = 2'b01,
    BPS_RUN = 2'b10
  } bps_mode_t;
  // Gate phases within a switching cycle.
  typedef enum logic [2:0] {
    BPS_LOW_ON = 3'b000,
    BPS_DT_RISE = 3'b001,
    BPS_HIGH_ON = 3'b010,
    BPS_DT_FALL = 3'b011,
    BPS_IDLE = 3'b100
  } bps_gate_t;
endpackage

// ==== bps_softstart.sv ====
`timescale 1ns/100ps
module bps_softstart (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Control.
  input wire logic restart,
  input wire logic run,
  input wire logic fast_variant,
  input wire logic sw_cycle,
  // Status.
  output logic [5:0] dac_code,
  output logic done
);
  logic [11:0] div_cnt;
  logic [11:0] next_div_cnt;
  logic [5:0] next_dac_code;
  logic [11:0] div_last;

  // Step size in switching cycles depends on variant.
  always_comb begin
    div_last = (fast_variant ? bps_pkg::SS_DIV_FAST : bps_pkg::SS_DIV_STD) - 12'h001;
    next_div_cnt = div_cnt;
    next_dac_code = dac_code;
    if (restart) begin
      next_div_cnt = 12'h000;
      next_dac_code = bps_pkg::SS_CODE_MIN;
    end else if (run && sw_cycle && !(dac_code == bps_pkg::SS_CODE_MAX && div_cnt == div_last))
        begin
      // The divider keeps counting on the top code so the last step lasts a full step time.
      if (div_cnt == div_last) begin
        next_div_cnt = 12'h000;
        next_dac_code = dac_code + 6'h01;
      end else begin
        next_div_cnt = div_cnt + 12'h001;
      end
    end
  end

  // Registers only; the code saturates at the top value and holds there.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_cnt <= 12'h000;
      dac_code <= bps_pkg::SS_CODE_MIN;
    end else begin
      div_cnt <= next_div_cnt;
      dac_code <= next_dac_code;
    end
  end

  // Complete on the last switching cycle of the final step, so the ramp spans the whole period.
  assign done = (dac_code == bps_pkg::SS_CODE_MAX) && (div_cnt == div_last) && sw_cycle;

  a_code_mono: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(restart) |-> dac_code >= $past(dac_code)) else $error("Soft-start code fell.");
endmodule // bps_softstart

// ==== bps_gate_seq.sv ====
`timescale 1ns/100ps
module bps_gate_seq (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Control.
  input wire logic enable,
  input wire logic sw_cycle,
  input wire logic max_duty,
  // Comparators.
  input wire logic pwm_trip,
  input wire logic peak_limit,
  input wire logic short_trip,
  input wire logic high_sensed_on,
  input wire logic low_sensed_on,
  // Gate commands.
  output logic high_gate_drive,
  output logic low_gate_drive,
  output logic skip_event
);
  bps_pkg::bps_gate_t phase;
  bps_pkg::bps_gate_t next_phase;
  logic next_high;
  logic next_low;
  logic next_skip;
  logic pending;
  logic next_pending;

  // Cycle phases: a start request waits for the low gate to be sensed off.
  always_comb begin
    next_phase = phase;
    next_pending = pending;
    next_skip = 1'b0;
    if (!enable) begin
      next_phase = bps_pkg::BPS_IDLE;
      next_pending = 1'b0;
    end else begin
      if (sw_cycle) begin
        next_pending = 1'b1;
      end
      unique case (phase)
        bps_pkg::BPS_IDLE: next_phase = bps_pkg::BPS_LOW_ON;
        bps_pkg::BPS_LOW_ON: begin
          if (pending || sw_cycle) begin
            if (short_trip) begin
              next_skip = sw_cycle;
            end else begin
              next_phase = bps_pkg::BPS_DT_RISE;
              next_pending = 1'b0;
            end
          end
        end
        bps_pkg::BPS_DT_RISE: begin
          if (!low_sensed_on) begin
            next_phase = bps_pkg::BPS_HIGH_ON;
          end
        end
        bps_pkg::BPS_HIGH_ON: begin
          if (pwm_trip || peak_limit || max_duty) begin
            next_phase = bps_pkg::BPS_DT_FALL;
          end
        end
        bps_pkg::BPS_DT_FALL: begin
          if (!high_sensed_on) begin
            next_phase = bps_pkg::BPS_LOW_ON;
          end
        end
        default: next_phase = bps_pkg::BPS_IDLE;
      endcase
    end
    next_high = (next_phase == bps_pkg::BPS_HIGH_ON);
    next_low = (next_phase == bps_pkg::BPS_LOW_ON);
  end

  // Gate commands are registered so they never glitch.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= bps_pkg::BPS_IDLE;
      pending <= 1'b0;
      high_gate_drive <= 1'b0;
      low_gate_drive <= 1'b0;
      skip_event <= 1'b0;
    end else begin
      phase <= next_phase;
      pending <= next_pending;
      high_gate_drive <= next_high;
      low_gate_drive <= next_low;
      skip_event <= next_skip;
    end
  end

  a_no_overlap: assert property (@(posedge core_clk) disable iff (!resetn)
    !(high_gate_drive && low_gate_drive)) else $error("Both gates on.");
  a_high_waits: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(high_gate_drive) |-> !$past(low_sensed_on)) else $error("High on while low sensed.");
  a_low_waits: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(low_gate_drive) && $past(phase) == bps_pkg::BPS_DT_FALL |-> !$past(high_sensed_on))
    else $error("Low on while high sensed.");
  a_trip_off: assert property (@(posedge core_clk) disable iff (!resetn)
    high_gate_drive && pwm_trip |=> !high_gate_drive) else $error("High stayed on after trip.");
  a_limit_off: assert property (@(posedge core_clk) disable iff (!resetn)
    high_gate_drive && peak_limit |=> !high_gate_drive) else $error("High on past limit.");
  a_short_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    enable && low_gate_drive && short_trip |=> !high_gate_drive) else $error("Skip failed.");
  a_off_gates: assert property (@(posedge core_clk) disable iff (!resetn)
    !enable |=> !high_gate_drive && !low_gate_drive) else $error("Gates on while disabled.");
endmodule // bps_gate_seq

// ==== buck_pwm_sequencer.sv ====
`timescale 1ns/100ps
module buck_pwm_sequencer (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Variant straps.
  input wire logic fast_variant,
  input wire logic limit_selectable,
  input wire logic [1:0] limit_select_pin,
  // Switching oscillator timing.
  input wire logic sw_cycle,
  input wire logic max_duty,
  // Startup and fault comparators.
  input wire logic supply_low_lockout,
  input wire logic ref_ok,
  input wire logic bias_ready,
  input wire logic thermal_hot,
  input wire logic comp_pulled_low,
  // Current comparators and gate sensing.
  input wire logic pwm_trip,
  input wire logic peak_limit,
  input wire logic short_trip,
  input wire logic high_sensed_on,
  input wire logic low_sensed_on,
  // Gate commands.
  output logic high_gate_drive,
  output logic low_gate_drive,
  // Analog settings.
  output logic [1:0] short_thresh_sel,
  output logic [5:0] ss_dac_code,
  // Status.
  output logic in_regulation,
  output logic soft_starting,
  output logic lockout_seen,
  output logic thermal_seen,
  output logic short_skip_seen
);
  bps_pkg::bps_mode_t mode;
  bps_pkg::bps_mode_t next_mode;
  logic conds_ok;
  logic ss_done;
  logic ss_restart;
  logic skip_event;
  logic [1:0] next_short_thresh_sel;
  logic next_lockout_seen;
  logic next_thermal_seen;
  logic next_short_skip_seen;

  // The supply comparator carries its own 2.75V/2.8V hysteresis, so a
  // clean level is enough here; no digital filter is added.
  assign conds_ok = !supply_low_lockout && ref_ok && bias_ready && !thermal_hot
                    && !comp_pulled_low;

  // Startup mode: any loss of conditions drops to off and rearms soft-start.
  always_comb begin
    next_mode = mode;
    unique case (mode)
      bps_pkg::BPS_OFF: begin
        if (conds_ok) begin
          next_mode = bps_pkg::BPS_SOFT;
        end
      end
      bps_pkg::BPS_SOFT: begin
        if (!conds_ok) begin
          next_mode = bps_pkg::BPS_OFF;
        end else if (ss_done) begin
          next_mode = bps_pkg::BPS_RUN;
        end
      end
      bps_pkg::BPS_RUN: begin
        if (!conds_ok) begin
          next_mode = bps_pkg::BPS_OFF;
        end
      end
      default: next_mode = bps_pkg::BPS_OFF;
    endcase
  end

  assign ss_restart = (mode == bps_pkg::BPS_OFF);

  // Threshold decode; fixed-threshold parts ignore the pin.
  always_comb begin
    next_short_thresh_sel = bps_pkg::SC_TH_210MV;
    if (limit_selectable) begin
      unique case (limit_select_pin)
        bps_pkg::LIM_HIGH: next_short_thresh_sel = bps_pkg::SC_TH_320MV;
        bps_pkg::LIM_LOW: next_short_thresh_sel = bps_pkg::SC_TH_105MV;
        default: next_short_thresh_sel = bps_pkg::SC_TH_210MV;
      endcase
    end
  end

  // Sticky flags: set only, cleared by reset alone.
  always_comb begin
    next_lockout_seen = lockout_seen || supply_low_lockout;
    next_thermal_seen = thermal_seen || thermal_hot;
    next_short_skip_seen = short_skip_seen || skip_event;
  end

  // State registers for mode, threshold and flags.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode <= bps_pkg::BPS_OFF;
      short_thresh_sel <= bps_pkg::SC_TH_210MV;
      lockout_seen <= 1'b0;
      thermal_seen <= 1'b0;
      short_skip_seen <= 1'b0;
    end else begin
      mode <= next_mode;
      short_thresh_sel <= next_short_thresh_sel;
      lockout_seen <= next_lockout_seen;
      thermal_seen <= next_thermal_seen;
      short_skip_seen <= next_short_skip_seen;
    end
  end

  assign in_regulation = (mode == bps_pkg::BPS_RUN);
  assign soft_starting = (mode == bps_pkg::BPS_SOFT);

  // Soft-start DAC ramp counted in switching cycles.
  bps_softstart u_ss (
    .core_clk(core_clk),
    .resetn(resetn),
    .restart(ss_restart),
    .run(soft_starting),
    .fast_variant(fast_variant),
    .sw_cycle(sw_cycle),
    .dac_code(ss_dac_code),
    .done(ss_done)
  );

  // Gate sequencing runs while soft-start or regulation is active.
  bps_gate_seq u_gate (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(conds_ok && mode != bps_pkg::BPS_OFF),
    .sw_cycle(sw_cycle),
    .max_duty(max_duty),
    .pwm_trip(pwm_trip),
    .peak_limit(peak_limit),
    .short_trip(short_trip),
    .high_sensed_on(high_sensed_on),
    .low_sensed_on(low_sensed_on),
    .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive),
    .skip_event(skip_event)
  );

  a_supply_low_lockout_gates: assert property (@(posedge core_clk) disable iff (!resetn)
    supply_low_lockout |=> ##1 !high_gate_drive && !low_gate_drive) else $error("Gates in lockout.");
  a_shdn_gates: assert property (@(posedge core_clk) disable iff (!resetn)
    comp_pulled_low [*2] |=> !high_gate_drive && !low_gate_drive) else $error("Gates in shutdown.");
  a_restart_low: assert property (@(posedge core_clk) disable iff (!resetn)
    mode == bps_pkg::BPS_OFF |=> ss_dac_code == bps_pkg::SS_CODE_MIN) else $error("No rearm.");
  a_start_soft: assert property (@(posedge core_clk) disable iff (!resetn)
    mode == bps_pkg::BPS_OFF |=> mode != bps_pkg::BPS_RUN) else $error("Skipped soft-start.");
  a_reg_full: assert property (@(posedge core_clk) disable iff (!resetn)
    in_regulation |-> ss_dac_code == bps_pkg::SS_CODE_MAX) else $error("Regulating below top.");
  a_thresh_fix: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(limit_selectable) |-> short_thresh_sel == bps_pkg::SC_TH_210MV)
    else $error("Fixed threshold wrong.");
  a_flag_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    thermal_hot |=> thermal_seen [*2]) else $error("Thermal flag lost.");
endmodule // buck_pwm_sequencer

// ==== bps_analog_model.sv ====
`timescale 1ns/100ps
// Stand-in for the gate drivers, their gate sensing and the PWM comparator.
module bps_analog_model (
  // Clock.
  input wire logic core_clk,
  // Gate commands.
  input wire logic high_gate_drive,
  input wire logic low_gate_drive,
  // Model settings.
  input wire logic slow,
  input wire logic [3:0] trip_len,
  // Sense and comparator outputs.
  output logic high_sensed_on,
  output logic low_sensed_on,
  output logic pwm_trip
);
  logic [2:0] hs = 3'h0;
  logic [2:0] ls = 3'h0;
  logic [3:0] on_cnt = 4'h0;
  // Gate charge drains in one or three clocks, so a slow gate stretches dead time.
  always @(posedge core_clk) begin
    hs <= {hs[1:0], high_gate_drive};
    ls <= {ls[1:0], low_gate_drive};
    on_cnt <= high_sensed_on ? on_cnt + 4'h1 : 4'h0;
  end
  assign high_sensed_on = slow ? hs[2] : hs[0];
  assign low_sensed_on = slow ? ls[2] : ls[0];
  // The summed sense crosses the error voltage after trip_len clocks of on-time.
  assign pwm_trip = high_sensed_on && (on_cnt >= trip_len);
endmodule // bps_analog_model

// ==== tb_buck_pwm_sequencer.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_buck_pwm_sequencer;
  localparam int P = 16;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic fast_variant = 1'b0;
  logic limit_selectable = 1'b0;
  logic [1:0] limit_select_pin = bps_pkg::LIM_FLOAT;
  logic sw_cycle = 1'b0;
  logic max_duty = 1'b0;
  logic peak_limit = 1'b0;
  logic short_trip = 1'b0;
  logic [4:0] flt = 5'h00;
  logic slow = 1'b0;
  logic [3:0] trip_len = 4'h2;
  logic pwm_trip, high_sensed_on, low_sensed_on, high_gate_drive, low_gate_drive;
  logic [1:0] short_thresh_sel;
  logic [5:0] ss_dac_code;
  logic in_regulation, soft_starting, lockout_seen, thermal_seen, short_skip_seen;
  logic prev_h = 1'b0, prev_l = 1'b0, prev_hs = 1'b0, prev_ls = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int hi_cnt = 0;
  int h0;

  // Free-running 20 MHz clock.
  always #25 core_clk = ~core_clk;

  // Fault bits: lockout, reference low, bias not ready, overtemp, shutdown.
  buck_pwm_sequencer dut_u (
    .core_clk(core_clk), .resetn(resetn), .fast_variant(fast_variant),
    .limit_selectable(limit_selectable), .limit_select_pin(limit_select_pin),
    .sw_cycle(sw_cycle), .max_duty(max_duty), .supply_low_lockout(flt[0]),
    .ref_ok(!flt[1]), .bias_ready(!flt[2]), .thermal_hot(flt[3]),
    .comp_pulled_low(flt[4]), .pwm_trip(pwm_trip), .peak_limit(peak_limit),
    .short_trip(short_trip), .high_sensed_on(high_sensed_on),
    .low_sensed_on(low_sensed_on), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .short_thresh_sel(short_thresh_sel),
    .ss_dac_code(ss_dac_code), .in_regulation(in_regulation),
    .soft_starting(soft_starting), .lockout_seen(lockout_seen),
    .thermal_seen(thermal_seen), .short_skip_seen(short_skip_seen));

  bps_analog_model far_u (
    .core_clk(core_clk), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .slow(slow), .trip_len(trip_len),
    .high_sensed_on(high_sensed_on), .low_sensed_on(low_sensed_on),
    .pwm_trip(pwm_trip));

  // Watches every rising edge for overlap and for turn-on before the other gate is sensed off.
  always @(posedge core_clk) begin
    `CHK(high_gate_drive & low_gate_drive, 1'b0)
    if (high_gate_drive && !prev_h) begin
      hi_cnt++;
      `CHK(prev_ls, 1'b0)
    end
    if (low_gate_drive && !prev_l) `CHK(prev_hs, 1'b0)
    prev_h = high_gate_drive;
    prev_l = low_gate_drive;
    prev_hs = high_sensed_on;
    prev_ls = low_sensed_on;
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Results are read at the falling edge, once the rising edge has settled.
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic sw_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) sw_cycle <= 1'b1;
      @(posedge core_clk) sw_cycle <= 1'b0;
      repeat (P - 2) @(posedge core_clk);
    end
    @(negedge core_clk);
  endtask

  task automatic t_thresh;
    logic [1:0] pins [4] = '{bps_pkg::LIM_LOW, bps_pkg::LIM_FLOAT, bps_pkg::LIM_HIGH,
      bps_pkg::LIM_HIGH};
    logic [1:0] exp [4] = '{bps_pkg::SC_TH_105MV, bps_pkg::SC_TH_210MV,
      bps_pkg::SC_TH_320MV, bps_pkg::SC_TH_210MV};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      limit_selectable <= (i < 3);
      limit_select_pin <= pins[i];
      settle(2);
      `CHK(short_thresh_sel, exp[i])
    end
  endtask

  // Full soft-start, partly with slow gates so dead time stretches.
  task automatic t_start;
    settle(3);
    `CHK({soft_starting, in_regulation}, 2'h2)
    h0 = hi_cnt;
    sw_pulses(16);
    `CHK(ss_dac_code, 6'h01)
    @(posedge core_clk) slow <= 1'b1;
    sw_pulses(992);
    `CHK({soft_starting, ss_dac_code}, 7'h7f)
    @(posedge core_clk) slow <= 1'b0;
    sw_pulses(16);
    `CHK({in_regulation, ss_dac_code}, 7'h7f)
    `CHK(hi_cnt - h0, 1024)
  endtask

  task automatic t_short;
    @(posedge core_clk) short_trip <= 1'b1;
    h0 = hi_cnt;
    sw_pulses(3);
    `CHK(hi_cnt - h0, 0)
    `CHK({low_gate_drive, short_skip_seen}, 2'h3)
    @(posedge core_clk) short_trip <= 1'b0;
    settle(P);
    `CHK(hi_cnt - h0, 1)
    sw_pulses(1);
    `CHK(hi_cnt - h0, 2)
  endtask

  // Peak limit, then max duty, each cut into a long on-time.
  task automatic t_cutoff;
    @(posedge core_clk) trip_len <= 4'hf;
    for (int c = 0; c < 2; c++) begin
      @(posedge core_clk) sw_cycle <= 1'b1;
      @(posedge core_clk) sw_cycle <= 1'b0;
      for (int i = 0; i < P && high_gate_drive !== 1'b1; i++) @(negedge core_clk);
      if (high_gate_drive !== 1'b1) begin
        n_errors++;
        summarize();
      end
      @(posedge core_clk);
      peak_limit <= (c == 0);
      max_duty <= (c == 1);
      settle(2);
      `CHK(high_gate_drive, 1'b0)
      @(posedge core_clk);
      peak_limit <= 1'b0;
      max_duty <= 1'b0;
      settle(P);
    end
    @(posedge core_clk) trip_len <= 4'h2;
  endtask

  task automatic t_faults;
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk) flt <= 5'h01 << k;
      settle(3);
      `CHK({high_gate_drive, low_gate_drive}, 2'h0)
      `CHK({soft_starting, in_regulation, ss_dac_code}, 8'h00)
      @(posedge core_clk) flt <= 5'h00;
      settle(3);
      `CHK(soft_starting, 1'b1)
      sw_pulses(16);
      `CHK(ss_dac_code, 6'h01)
    end
    `CHK({lockout_seen, thermal_seen}, 2'h3)
  endtask

  // The fast variant steps only every 64 switching cycles.
  task automatic t_fast;
    @(posedge core_clk);
    fast_variant <= 1'b1;
    flt <= 5'h01;
    settle(3);
    @(posedge core_clk) flt <= 5'h00;
    sw_pulses(63);
    `CHK(ss_dac_code, 6'h00)
    sw_pulses(1);
    `CHK(ss_dac_code, 6'h01)
  endtask

  // Main sequence: reset state first, then each scenario in turn.
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK({high_gate_drive, low_gate_drive, ss_dac_code}, 8'h00)
    `CHK({lockout_seen, thermal_seen, short_skip_seen}, 3'h0)
    `CHK(short_thresh_sel, bps_pkg::SC_TH_210MV)
    @(posedge core_clk) resetn <= 1'b1;
    t_thresh();
    t_start();
    t_short();
    t_cutoff();
    t_faults();
    t_fast();
    summarize();
  end
endmodule // tb_buck_pwm_sequencer
